// ===== src/charge_seq_consts.svh
`ifndef CHARGE_SEQ_CONSTS_SVH
`define CHARGE_SEQ_CONSTS_SVH

// voltage margins and temperatures as printed
`define LOCKOUT_HYST_MV      100
`define SUPPLY_START_MV      150
`define SUPPLY_STOP_MV       50
`define NO_BATT_MARGIN_MV    100
`define THERM_TRIP_C         150
`define THERM_COOL_C         10

// regulation target options in millivolts
`define REG_OPT0_MV          4200
`define REG_OPT1_MV          4350
`define REG_OPT2_MV          4400
`define REG_OPT3_MV          4500

// termination filter time and clock
`define TERM_FILTER_US       1000
`define CLK_PERIOD_NS        4
`define TERM_FILTER_CYC      ((`TERM_FILTER_US * 1000) / `CLK_PERIOD_NS)

// register map
`define ADDR_CTRL            12'h000
`define ADDR_STATUS          12'h004
`define ADDR_INPUTS          12'h008
`define CTRL_RESET           32'h0000_0000
`define CTRL_VARIANT_BIT     0
`define CTRL_REGSEL_LSB      1

`endif

// ===== src/charge_seq_pkg.sv
package charge_seq_pkg;

  typedef enum logic [8:0] {
    ST_SHUTDOWN  = 9'h001,
    ST_DETECT    = 9'h002,
    ST_NO_BATT   = 9'h004,
    ST_PRECOND   = 9'h008,
    ST_CC        = 9'h010,
    ST_CV        = 9'h020,
    ST_COMPLETE  = 9'h040,
    ST_DISABLED  = 9'h080,
    ST_QUALIFY   = 9'h100
  } charge_state_t;

  // comparator results from the analog front end
  typedef struct packed {
    logic supply_above_lockout;
    logic supply_above_lockout_hyst;
    logic supply_150_above_batt;
    logic supply_50_above_batt;
    logic batt_above_no_batt;
    logic batt_above_precond;
    logic batt_at_reg;
    logic batt_below_recharge;
    logic current_below_term;
    logic die_over_trip;
    logic die_cooled;
    logic current_set_enable_in;
  } comp_in_t;

  typedef struct packed {
    logic trickle_sel;
    logic full_sel;
    logic cv_sel;
    logic thermal_limit;
    logic charge_on;
  } mode_out_t;

  typedef struct packed {
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
  } apb_req_t;

  typedef struct packed {
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } apb_rsp_t;

endpackage : charge_seq_pkg

// ===== src/li_cell_charge_sequencer.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "charge_seq_consts.svh"

module li_cell_charge_sequencer #(
  parameter int unsigned TERM_FILTER_CYC = `TERM_FILTER_CYC,
  parameter logic [1:0]  REG_OPTION      = 2'h0,
  parameter logic        OPEN_DRAIN      = 1'b0
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire charge_seq_pkg::apb_req_t apb_req,
  output      charge_seq_pkg::apb_rsp_t apb_rsp,
  // comparators
  input  wire charge_seq_pkg::comp_in_t comp_in,
  // current mode selects
  output      charge_seq_pkg::mode_out_t mode_out,
  output      logic [1:0]               regulation_voltage_sel,
  // status pin
  output      logic                     status_out,
  output      logic                     status_oe
);
  import charge_seq_pkg::*;

  localparam int unsigned CW = $clog2(TERM_FILTER_CYC + 1);

  typedef struct packed {
    comp_in_t       sync1;
    comp_in_t       sync2;
    charge_state_t  state;
    logic           therm_susp;
    logic [CW-1:0]  term_cnt;
    logic           lockout;
    logic           variant_od;
    logic [1:0]     reg_sel;
    apb_rsp_t       rsp;
    mode_out_t      mode;
    logic [1:0]     reg_out;
    logic           stat_o;
    logic           stat_oe;
  } seq_state_t;

  seq_state_t cur;
  seq_state_t next_cur;

  comp_in_t c;
  logic     lockout_now;
  logic     enabled;
  logic     wr;
  logic     rd;

  always_comb begin
    next_cur     = cur;
    c            = cur.sync2;
    lockout_now  = 1'b0;
    enabled      = 1'b0;
    wr           = 1'b0;
    rd           = 1'b0;

    // two-flop synchronisers
    next_cur.sync1 = comp_in;
    next_cur.sync2 = cur.sync1;

    // lockout with hysteresis and battery margins
    if (cur.lockout) begin
      if (c.supply_above_lockout_hyst && c.supply_150_above_batt) begin
        next_cur.lockout = 1'b0;
      end
    end else begin
      if (!c.supply_above_lockout || !c.supply_50_above_batt) begin
        next_cur.lockout = 1'b1;
      end
    end
    lockout_now = next_cur.lockout;
    enabled     = c.current_set_enable_in;

    // thermal suspend, phase kept
    if (cur.therm_susp) begin
      if (c.die_cooled) begin
        next_cur.therm_susp = 1'b0;
      end
    end else if (c.die_over_trip) begin
      next_cur.therm_susp = 1'b1;
    end

    // termination filter counter
    if (cur.state == ST_CV && c.current_below_term) begin
      if (cur.term_cnt < CW'(TERM_FILTER_CYC)) begin
        next_cur.term_cnt = cur.term_cnt + CW'(1);
      end
    end else begin
      next_cur.term_cnt = '0;
    end

    if (lockout_now) begin
      next_cur.state = ST_SHUTDOWN;
    end else if (!enabled) begin
      next_cur.state = ST_DISABLED;
    end else begin
      case (cur.state)
        ST_SHUTDOWN, ST_DISABLED: begin
          next_cur.state = ST_DETECT;
        end
        ST_DETECT, ST_NO_BATT: begin
          if (c.batt_above_no_batt) begin
            next_cur.state = ST_NO_BATT;
          end else begin
            next_cur.state = ST_QUALIFY;
          end
        end
        ST_QUALIFY: begin
          if (c.batt_above_no_batt) begin
            next_cur.state = ST_NO_BATT;
          end else if (!c.batt_above_precond) begin
            next_cur.state = ST_PRECOND;
          end else if (c.batt_at_reg) begin
            next_cur.state = ST_CV;
          end else begin
            next_cur.state = ST_CC;
          end
        end
        ST_PRECOND: begin
          if (c.batt_above_precond) begin
            next_cur.state = ST_CC;
          end
        end
        ST_CC: begin
          if (c.batt_at_reg) begin
            next_cur.state = ST_CV;
          end
        end
        ST_CV: begin
          if (cur.term_cnt >= CW'(TERM_FILTER_CYC - 1)
              && c.current_below_term) begin
            next_cur.state = ST_COMPLETE;
          end
        end
        ST_COMPLETE: begin
          if (c.batt_above_no_batt) begin
            next_cur.state = ST_NO_BATT;
          end else if (c.batt_below_recharge) begin
            next_cur.state = ST_QUALIFY;
          end
        end
        default: begin
          next_cur.state = ST_SHUTDOWN;
        end
      endcase
    end

    // current mode selects, thermal overrides
    next_cur.mode = '0;
    if (!next_cur.therm_susp) begin
      next_cur.mode.trickle_sel = (next_cur.state == ST_PRECOND);
      next_cur.mode.full_sel    = (next_cur.state == ST_CC);
      next_cur.mode.cv_sel      = (next_cur.state == ST_CV);
    end
    next_cur.mode.charge_on = next_cur.mode.trickle_sel
                            | next_cur.mode.full_sel
                            | next_cur.mode.cv_sel;
    next_cur.mode.thermal_limit = next_cur.therm_susp;
    next_cur.reg_out = cur.reg_sel;

    // status pin
    case (next_cur.state)
      ST_PRECOND, ST_CC, ST_CV: begin
        next_cur.stat_o  = 1'b0;
        next_cur.stat_oe = 1'b1;
      end
      ST_COMPLETE: begin
        next_cur.stat_o  = !cur.variant_od;
        next_cur.stat_oe = !cur.variant_od;
      end
      default: begin
        next_cur.stat_o  = 1'b0;
        next_cur.stat_oe = 1'b0;
      end
    endcase

    // apb slave, zero wait states
    next_cur.rsp.pready  = 1'b0;
    next_cur.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      next_cur.rsp.pready = 1'b1;
      wr = apb_req.pwrite;
      rd = !apb_req.pwrite;
      case (apb_req.paddr)
        `ADDR_CTRL: begin
          if (wr) begin
            next_cur.variant_od = apb_req.pwdata[`CTRL_VARIANT_BIT];
            next_cur.reg_sel    = apb_req.pwdata[`CTRL_REGSEL_LSB +: 2];
          end
          next_cur.rsp.prdata = {29'h0, cur.reg_sel, cur.variant_od};
        end
        `ADDR_STATUS: begin
          if (wr) begin
            next_cur.rsp.pslverr = 1'b1;
          end
          next_cur.rsp.prdata = {21'h0, cur.lockout, cur.therm_susp,
                                 cur.state};
        end
        `ADDR_INPUTS: begin
          if (wr) begin
            next_cur.rsp.pslverr = 1'b1;
          end
          next_cur.rsp.prdata = {20'h0, cur.sync2};
        end
        default: begin
          next_cur.rsp.pslverr = 1'b1;
          next_cur.rsp.prdata  = 32'h0000_0000;
        end
      endcase
      if (!rd) begin
        next_cur.rsp.prdata = 32'h0000_0000;
      end
    end else begin
      next_cur.rsp.prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur            <= '0;
      cur.state      <= ST_SHUTDOWN;
      cur.lockout    <= 1'b1;
      cur.variant_od <= OPEN_DRAIN;
      cur.reg_sel    <= REG_OPTION;
    end else begin
      cur <= next_cur;
    end
  end

  assign apb_rsp                = cur.rsp;
  assign mode_out               = cur.mode;
  assign regulation_voltage_sel = cur.reg_out;
  assign status_out             = cur.stat_o;
  assign status_oe              = cur.stat_oe;

endmodule : li_cell_charge_sequencer

// ===== tb/charge_seq_properties.sv
`timescale 1ns/100ps
module charge_seq_properties #(
  parameter int unsigned TERM_FILTER_CYC = 20
) (
  // clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // watched ports
  input wire charge_seq_pkg::apb_req_t  apb_req,
  input wire charge_seq_pkg::apb_rsp_t  apb_rsp,
  input wire charge_seq_pkg::comp_in_t  comp_in,
  input wire charge_seq_pkg::mode_out_t mode_out,
  input wire logic [1:0]                regulation_voltage_sel,
  input wire logic                      status_out,
  input wire logic                      status_oe
);
  import charge_seq_pkg::*;
  int unsigned run;
  logic [2:0]  sel;
  assign sel = {mode_out.trickle_sel, mode_out.full_sel, mode_out.cv_sel};
  // consecutive low-current cycles
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) run <= 0;
    else run <= comp_in.current_below_term ? run + 1 : 0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (apb_req.psel && !apb_req.penable
    |=> apb_rsp.pready) else $error("no answer after setup");
  AST_LOCKOUT_OFF: assert property (
    !comp_in.supply_above_lockout |-> ##3 !mode_out.charge_on)
    else $error("charging under lockout");
  AST_STOP_OFF: assert property (
    !comp_in.supply_50_above_batt |-> ##3 !mode_out.charge_on)
    else $error("charging near battery level");
  AST_DISABLE_OFF: assert property (
    !comp_in.current_set_enable_in |-> ##3 !mode_out.charge_on)
    else $error("charging while disabled");
  AST_ONE_MODE: assert property ($onehot0(sel))
    else $error("several current modes");
  AST_HOT_ZERO: assert property (
    comp_in.die_over_trip |-> ##3 sel == 3'h0)
    else $error("current while hot");
  AST_STAT_LOW: assert property (
    sel != 3'h0 |-> status_oe && !status_out)
    else $error("status not low while charging");
  AST_IDLE_SEL: assert property (
    !mode_out.charge_on |-> sel == 3'h0)
    else $error("mode select without charge");
  AST_TERM_FILTER: assert property (
    $fell(mode_out.cv_sel) && !mode_out.thermal_limit
    && comp_in.current_set_enable_in && comp_in.supply_above_lockout
    |-> run >= TERM_FILTER_CYC) else $error("early termination");
  cover property ($fell(mode_out.cv_sel));
  cover property (mode_out.thermal_limit);
  cover property (apb_rsp.pslverr);
  cover property (status_out && status_oe);
endmodule : charge_seq_properties

bind li_cell_charge_sequencer charge_seq_properties #(
  .TERM_FILTER_CYC(TERM_FILTER_CYC)) prop_u (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .comp_in(comp_in), .mode_out(mode_out),
  .regulation_voltage_sel(regulation_voltage_sel),
  .status_out(status_out), .status_oe(status_oe));

// ===== tb/cell_model.sv
`timescale 1ns/100ps
module cell_model (
  // clock
  input  wire logic                      pclk,
  // knobs: drain, no cell, hot, enable, supply
  input  wire logic [4:0]                env,
  // supply comparators forced low: lockout, hyst, 150, 50
  input  wire logic [3:0]                sup_off,
  // charger side
  input  wire charge_seq_pkg::mode_out_t mode_out,
  output      charge_seq_pkg::comp_in_t  comp_in
);
  import charge_seq_pkg::*;
  int vb = 0;
  // cell voltage rises while charged
  always @(posedge pclk)
    if (env[4]) vb <= 0;
    else if (mode_out.charge_on && vb < 400) vb <= vb + 1;
  assign comp_in = {{4{env[0]}} & ~sup_off, env[3], vb > 100, vb > 200,
                    vb < 250,
                    vb > 300, env[2], !env[2], env[1]};
endmodule : cell_model

// ===== tb/li_cell_charge_sequencer_tb.sv
`timescale 1ns/100ps
`include "charge_seq_consts.svh"
module li_cell_charge_sequencer_tb;
  import charge_seq_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  comp_in_t    comp_in;
  mode_out_t   mode_out;
  logic [1:0]  regulation_voltage_sel;
  logic        status_out;
  logic        status_oe;
  logic [4:0]  env = 5'h00;
  logic [3:0]  sup_off = 4'h0;
  logic [31:0] rd;
  logic        perr;
  int          err_total = 0;
  int          n_tests = 0;

  li_cell_charge_sequencer #(.TERM_FILTER_CYC(20)) dut_u (.pclk(pclk),
    .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .comp_in(comp_in),
    .mode_out(mode_out), .regulation_voltage_sel(regulation_voltage_sel),
    .status_out(status_out), .status_oe(status_oe));
  cell_model cell_u (.pclk(pclk), .env(env), .sup_off(sup_off),
    .mode_out(mode_out), .comp_in(comp_in));

  initial forever #2 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    perr = rsp.pslverr;
    req <= '0;
  endtask : xfer

  task automatic wait_st(input logic [8:0] s);
    for (int i = 0; i < 400; i++) begin
      xfer(1'b0, `ADDR_STATUS, 32'h0);
      if (rd[8:0] === s) break;
    end
    chk("state", s, rd[8:0]);
  endtask : wait_st

  task automatic set_env(input logic [4:0] v);
    @(posedge pclk);
    env <= v;
    repeat (4) @(posedge pclk);
  endtask : set_env

  task automatic t_reset;
    xfer(1'b0, `ADDR_CTRL, 32'h0);
    chk("ctrl", `CTRL_RESET, rd);
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("status", 32'h401, rd);
    xfer(1'b0, `ADDR_INPUTS, 32'h0);
    chk("inputs", 32'h012, rd);
    xfer(1'b0, 12'hFFC, 32'h0);
    chk("bad addr", 1'h1, perr);
    xfer(1'b1, `ADDR_STATUS, 32'hF);
    chk("ro write", 1'h1, perr);
    chk("oe", 1'h0, status_oe);
    $display("test reset done");
  endtask : t_reset

  task automatic t_charge;
    set_env(5'h03);
    wait_st(9'h008);
    chk("precond", 5'h11, mode_out);
    chk("pin", 2'h1, {status_out, status_oe});
    wait_st(9'h010);
    chk("cc", 5'h09, mode_out);
    wait_st(9'h020);
    chk("cv", 5'h05, mode_out);
    wait_st(9'h040);
    chk("done", 5'h00, mode_out);
    chk("pin", 2'h3, {status_out, status_oe});
    set_env(5'h13);
    set_env(5'h03);
    wait_st(9'h008);
    $display("test charge done");
  endtask : t_charge

  task automatic t_faults;
    set_env(5'h07);
    chk("hot sel", 4'h1, mode_out[4:1]);
    wait_st(9'h008);
    chk("hot flag", 1'h1, rd[9]);
    set_env(5'h03);
    chk("cool sel", 1'h1, |mode_out[4:2]);
    set_env(5'h01);
    wait_st(9'h080);
    chk("off", 5'h00, mode_out);
    set_env(5'h13);
    set_env(5'h03);
    wait_st(9'h008);
    set_env(5'h02);
    wait_st(9'h001);
    chk("oe", 1'h0, status_oe);
    set_env(5'h0B);
    wait_st(9'h004);
    chk("oe", 1'h0, status_oe);
    $display("test faults done");
  endtask : t_faults

  task automatic sup_chk(input logic [3:0] m, input logic [31:0] e);
    @(posedge pclk);
    sup_off <= m;
    repeat (4) @(posedge pclk);
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("undervoltage_lockout", e, rd);
  endtask : sup_chk

  task automatic t_lockout;
    sup_chk(4'h6, 32'h004);
    sup_chk(4'h7, 32'h401);
    sup_chk(4'h6, 32'h401);
    sup_chk(4'h2, 32'h401);
    sup_chk(4'h0, 32'h004);
    $display("test lockout done");
  endtask : t_lockout

  task automatic t_variant;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `ADDR_CTRL, {29'h0, i[1:0], 1'b1});
      repeat (2) @(posedge pclk);
      chk("reg sel", i[1:0], regulation_voltage_sel);
    end
    set_env(5'h13);
    set_env(5'h03);
    wait_st(9'h008);
    chk("od chg", 2'h1, {status_out, status_oe});
    wait_st(9'h040);
    chk("od pin", 1'h0, status_oe);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("rst status", 32'h401, rd);
    xfer(1'b0, `ADDR_CTRL, 32'h0);
    chk("rst ctrl", `CTRL_RESET, rd);
    $display("test variant done");
  endtask : t_variant

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_charge();
    t_faults();
    t_lockout();
    t_variant();
    results();
  end

  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule : li_cell_charge_sequencer_tb
